/* design/tape_char_gating_and_staging.sv */
// Character gating, track hold, skew check and read staging with AXI regs
// Operation
// - write skew gate follows char detect clock
// - three density timers, selected one, qualified
// - read accept gate follows char detect clock
// - acceptance spans detect clock plus accept gate
// - accept gate 17, 6, 4 us
// - hold gate while host step b only
// - block gate on start, gap timer, halt
// - write toggles hold flops, read sets
// - clear holds at start and hold clear
// - inhibit holds in gap except check window
// - first pulse in skew gate flags fault
// - skew fault fires fault pulse one-shot
// - stage only when previous character delivered
// - load with gate, else wait host step a
// - hold flops keep character until staged
// - staging load fires 0.5 us hold clear
// - ready flag shows staging register full
// - host step b clears ready flag
// - new gate while ready sets both-full
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "tape_char_map.svh"
`default_nettype none
module tape_char_gating_and_staging
  import tape_char_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire tape_pins_t pins,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output var  logic       s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output var  logic       s_axi_wready,
  output var  logic [1:0] s_axi_bresp,
  output var  logic       s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output var  logic       s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0] s_axi_rresp,
  output var  logic       s_axi_rvalid,
  input  wire logic       s_axi_rready,
  output var  logic       write_skew_gate,
  output var  logic       read_accept_gate,
  output var  logic [6:0] staging_reg,
  output var  logic       char_ready,
  output var  logic       both_full,
  output var  logic       skew_fault,
  output var  logic       fault_pulse
);

  function automatic logic [2:0] dens_hot(input density_t d);
    dens_hot = 3'h0;
    case (d)
      DENS_A:  dens_hot = 3'h1;
      DENS_B:  dens_hot = 3'h2;
      DENS_C:  dens_hot = 3'h4;
      default: dens_hot = 3'h0;
    endcase
  endfunction

  localparam tmr_t RAG_CYC [3] = '{12'(`NS2CYC(`RAG_A_NS)),
                                   12'(`NS2CYC(`RAG_B_NS)),
                                   12'(`NS2CYC(`RAG_C_NS))};
  localparam tmr_t WSG_CYC [3] = '{12'(`NS2CYC(`WSG_A_NS)),
                                   12'(`NS2CYC(`WSG_B_NS)),
                                   12'(`NS2CYC(`WSG_C_NS))};
  localparam tmr_t HCLR_CYC  = 12'(`NS2CYC(`HOLD_CLR_NS));
  localparam tmr_t FAULT_CYC = 12'(`NS2CYC(`FAULT_NS));

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser: pins are asynchronous, stage one feeds stage two only
  tape_pins_t meta_q, pin_q, prev_q;
  tape_pins_t meta_d, pin_d, prev_d;

  always_comb begin
    meta_d = pins;
    pin_d  = meta_q;
    prev_d = pin_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      pin_q  <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      pin_q  <= pin_d;
      prev_q <= prev_d;
    end
  end

  logic       rd_mode, wr_mode, cdc_done, op_start, halt;
  logic [2:0] sel;
  logic [6:0] trk_fall;
  logic       first_track_pulse, hold_b_only, ha_rise, hb_rise;
  density_t   dens_q;

  always_comb begin
    rd_mode  = pin_q.tape_op_active & ~pin_q.xfer_out_mode;
    wr_mode  = pin_q.tape_op_active & pin_q.xfer_out_mode;
    // Gates start when the detect clock period has expired
    cdc_done = prev_q.char_detect_clock & ~pin_q.char_detect_clock;
    trk_fall = prev_q.deskewed_track_pulses & ~pin_q.deskewed_track_pulses;
    first_track_pulse = |trk_fall & ~pin_q.first_pulse_lockout;
    hold_b_only = ~pin_q.host_accept_a & pin_q.host_accept_b;
    ha_rise  = pin_q.host_accept_a & ~prev_q.host_accept_a;
    hb_rise  = pin_q.host_accept_b & ~prev_q.host_accept_b;
    sel      = dens_hot(dens_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-density one-shots; only the selected timer may start
  tmr_t       wsg_q [3];
  tmr_t       rag_q [3];
  logic [2:0] wsg_on, rag_on;
  logic       wsg, cr;

  for (genvar i = 0; i < 3; i++) begin : g_dens
    tmr_t wsg_d, rag_d;
    always_comb begin
      wsg_d = (wsg_q[i] != 12'h0) ? wsg_q[i] - 12'h1 : 12'h0;
      rag_d = (rag_q[i] != 12'h0) ? rag_q[i] - 12'h1 : 12'h0;
      if (cdc_done && wr_mode && sel[i]) begin
        wsg_d = WSG_CYC[i];
      end
      if (cdc_done && rd_mode && sel[i]) begin
        rag_d = RAG_CYC[i];
      end
      if (hold_b_only && read_accept_gate && sel[i]) begin
        rag_d = RAG_CYC[i];
      end
      if (!sel[i]) begin
        wsg_d = 12'h0;
        rag_d = 12'h0;
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wsg_q[i] <= 12'h0;
        rag_q[i] <= 12'h0;
      end else begin
        wsg_q[i] <= wsg_d;
        rag_q[i] <= rag_d;
      end
    end
    assign wsg_on[i] = (wsg_q[i] != 12'h0) & sel[i];
    assign rag_on[i] = (rag_q[i] != 12'h0) & sel[i];
  end

  always_comb begin
    // Qualifying the OR masks glitches while the density is changing
    wsg = |wsg_on & ~op_start;
    cr  = |rag_on & ~op_start & ~pin_q.gap_timer_one & ~halt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Track hold flops, staging register and host handshake flags
  logic [6:0] hold_q, hold_d, stage_d;
  logic       rdy_d, full_d, skew_d, wsg_d, cr_d, fpulse_d;
  tmr_t       hclr_q, hclr_d, flt_q, flt_d;
  logic       load_clk, hold_clear, trk_en;

  always_comb begin
    trk_en     = ~pin_q.gap_crossing | pin_q.check_char_window;
    hold_clear = hclr_q != 12'h0;
    // Load with the gate, or after step a when both registers are full
    load_clk = rd_mode & ((cr & ~read_accept_gate & ~char_ready)
             | (both_full & ha_rise));
    hold_d = hold_q;
    if (trk_en) begin
      // Write bits toggle whenever track input is enabled; read bits land only during detect clock or accept gate time
      if (wr_mode) begin
        hold_d = hold_q ^ trk_fall;
      end else if (pin_q.char_detect_clock || read_accept_gate) begin
        hold_d = hold_q | trk_fall;
      end
    end
    if (op_start || (rd_mode && hold_clear)) begin
      hold_d = 7'h0;
    end
    hclr_d = hold_clear ? hclr_q - 12'h1 : 12'h0;
    if (load_clk) begin
      hclr_d = HCLR_CYC;
    end
    stage_d = load_clk ? hold_q : staging_reg;
    rdy_d   = char_ready;
    if (hb_rise) begin
      rdy_d = 1'b0;
    end
    if (load_clk) begin
      rdy_d = 1'b1;
    end
    full_d = both_full;
    if (both_full && ha_rise) begin
      full_d = 1'b0;
    end
    if (rd_mode && cr && !read_accept_gate && char_ready) begin
      full_d = 1'b1;
    end
    skew_d = skew_fault;
    if (!wsg) begin
      skew_d = 1'b0;
    end
    if (wr_mode && wsg && first_track_pulse) begin
      skew_d = 1'b1;
    end
    flt_d = (flt_q != 12'h0) ? flt_q - 12'h1 : 12'h0;
    if (skew_d && !skew_fault) begin
      flt_d = FAULT_CYC;
    end
    fpulse_d = flt_d != 12'h0;
    wsg_d    = wsg;
    cr_d     = cr;
    if (op_start) begin
      stage_d = 7'h0;
      rdy_d   = 1'b0;
      full_d  = 1'b0;
      skew_d  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q           <= 7'h0;
      staging_reg      <= 7'h0;
      char_ready       <= 1'b0;
      both_full        <= 1'b0;
      skew_fault       <= 1'b0;
      hclr_q           <= 12'h0;
      flt_q            <= 12'h0;
      fault_pulse      <= 1'b0;
      write_skew_gate  <= 1'b0;
      read_accept_gate <= 1'b0;
    end else begin
      hold_q           <= hold_d;
      staging_reg      <= stage_d;
      char_ready       <= rdy_d;
      both_full        <= full_d;
      skew_fault       <= skew_d;
      hclr_q           <= hclr_d;
      flt_q            <= flt_d;
      fault_pulse      <= fpulse_d;
      write_skew_gate  <= wsg_d;
      read_accept_gate <= cr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data taken in either order
  logic        aw_have_q, w_have_q, aw_have_d, w_have_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        halt_q, halt_d, start_q, start_d;
  density_t    dens_d;
  logic        bvalid_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic        do_wr;

  assign op_start = start_q;
  assign halt     = halt_q;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    do_wr    = aw_have_q && w_have_q && !s_axi_bvalid;
    dens_d   = dens_q;
    halt_d   = halt_q;
    start_d  = 1'b0;
    bvalid_d = s_axi_bvalid && !s_axi_bready;
    bresp_d  = s_axi_bresp;
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_SLVERR;
      if (awaddr_q[7:2] == 6'(`CTRL_OFF >> 2)) begin
        bresp_d = `RESP_OKAY;
        if (wstrb0_q) begin
          dens_d  = density_t'(wdata_q[`CTRL_DENS_MSB:`CTRL_DENS_LSB]);
          halt_d  = wdata_q[`CTRL_HALT_BIT];
          start_d = wdata_q[`CTRL_START_BIT];
        end
      end else if (awaddr_q[7:2] == 6'(`STATUS_OFF >> 2)
                || awaddr_q[7:2] == 6'(`STAGE_OFF >> 2)) begin
        bresp_d = `RESP_OKAY;
      end
    end
    rvalid_d = s_axi_rvalid && !s_axi_rready;
    rdata_d  = s_axi_rdata;
    rresp_d  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      rdata_d  = 32'h0;
      case (s_axi_araddr[7:2])
        6'(`CTRL_OFF >> 2): begin
          rdata_d[`CTRL_DENS_MSB:`CTRL_DENS_LSB] = dens_q;
          rdata_d[`CTRL_HALT_BIT] = halt_q;
        end
        6'(`STATUS_OFF >> 2): begin
          rdata_d[`ST_READY_BIT] = char_ready;
          rdata_d[`ST_FULL_BIT]  = both_full;
          rdata_d[`ST_SKEW_BIT]  = skew_fault;
          rdata_d[`ST_WSG_BIT]   = write_skew_gate;
          rdata_d[`ST_RAG_BIT]   = read_accept_gate;
          rdata_d[`ST_FAULT_BIT] = fault_pulse;
        end
        6'(`STAGE_OFF >> 2): begin
          rdata_d[6:0] = staging_reg;
        end
        default: begin
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h0;
      wdata_q       <= 32'h0;
      wstrb0_q      <= 1'b0;
      dens_q        <= DENS_A;
      halt_q        <= 1'b0;
      start_q       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb0_q      <= wstrb0_d;
      dens_q        <= dens_d;
      halt_q        <= halt_d;
      start_q       <= start_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rresp   <= rresp_d;
      s_axi_rdata   <= rdata_d;
      // Ready is registered, so it drops the cycle after a handshake
      s_axi_awready <= !aw_have_d && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_d && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !rvalid_d && !(s_axi_arvalid && s_axi_arready);
    end
  end

endmodule // tape_char_gating_and_staging
`default_nettype wire

/* design/tape_char_map.svh */
// Offsets, field positions, reset values and timing counts for char gating
`ifndef TAPE_CHAR_MAP_SVH
`define TAPE_CHAR_MAP_SVH

// Register byte offsets
`define CTRL_OFF       8'h00
`define STATUS_OFF     8'h04
`define STAGE_OFF      8'h08

// Control register fields
`define CTRL_DENS_LSB  0
`define CTRL_DENS_MSB  1
`define CTRL_HALT_BIT  2
`define CTRL_START_BIT 3
`define CTRL_RESET     2'h0

// Status register fields
`define ST_READY_BIT   0
`define ST_FULL_BIT    1
`define ST_SKEW_BIT    2
`define ST_WSG_BIT     3
`define ST_RAG_BIT     4
`define ST_FAULT_BIT   5

// AXI response codes
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// Clock rate and intervals; least times round up to whole cycles
`define CLK_MHZ        125
`define RAG_A_NS       17000
`define RAG_B_NS       6000
`define RAG_C_NS       4000
`define WSG_A_NS       2000
`define WSG_B_NS       1000
`define WSG_C_NS       1000
`define HOLD_CLR_NS    500
`define FAULT_NS       10000
`define NS2CYC(ns)     (((ns) * `CLK_MHZ + 999) / 1000)

`endif

/* design/tape_char_pkg.sv */
// Types shared by the character gating and staging block
`default_nettype none
package tape_char_pkg;
  typedef enum logic [1:0] {DENS_A, DENS_B, DENS_C} density_t;

  // Pins from the tape side, carried together through the synchroniser
  typedef struct packed {
    logic       char_detect_clock;
    logic       host_accept_a;
    logic       host_accept_b;
    logic       xfer_out_mode;
    logic       tape_op_active;
    logic       gap_timer_one;
    logic       check_char_window;
    logic       gap_crossing;
    logic       first_pulse_lockout;
    logic [6:0] deskewed_track_pulses;
  } tape_pins_t;

  typedef logic [11:0] tmr_t;
endpackage
`default_nettype wire

/* dv/char_checks_asserts.sv */
// Checker for character gating and staging outputs
`default_nettype none
module char_checks
  import tape_char_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       read_accept_gate,
  input wire logic       write_skew_gate,
  input wire logic [6:0] staging_reg,
  input wire logic       char_ready,
  input wire logic       both_full,
  input wire logic       skew_fault,
  input wire logic       fault_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  a_ready_gate: assert property (
    $rose(char_ready) |-> read_accept_gate || $past(read_accept_gate))
    else $error("ready rose without accept gate");
  a_stage_free: assert property (
    $changed(staging_reg) |-> !$past(char_ready) || $past(both_full)
      || staging_reg == 7'h00)
    else $error("staging overwritten while undelivered");
  a_full_rise: assert property (
    $rose(both_full) |-> char_ready && $past(char_ready))
    else $error("both full without ready");
  a_full_ready: assert property (both_full |-> char_ready)
    else $error("both full while ready low");
  a_skew_set: assert property (
    $rose(skew_fault) |-> write_skew_gate || $past(write_skew_gate))
    else $error("skew fault outside skew gate");
  a_skew_clear: assert property (
    !write_skew_gate [*2] |-> !skew_fault)
    else $error("skew fault kept with gate low");
  a_fault_fire: assert property (
    $rose(skew_fault) |-> ##[0:2] fault_pulse)
    else $error("fault pulse missing");
  a_fault_width: assert property (
    $rose(fault_pulse) |-> fault_pulse [*8])
    else $error("fault pulse too short");
  a_gates_apart: assert property (
    !(read_accept_gate && write_skew_gate))
    else $error("read and write gates together");
  cover property ($rose(both_full));
  cover property ($rose(fault_pulse));
  cover property ($fell(char_ready) && !both_full);
endmodule // char_checks

bind tape_char_gating_and_staging char_checks u_chk (
  .aclk(aclk), .aresetn(aresetn), .read_accept_gate(read_accept_gate),
  .write_skew_gate(write_skew_gate), .staging_reg(staging_reg),
  .char_ready(char_ready), .both_full(both_full),
  .skew_fault(skew_fault), .fault_pulse(fault_pulse));
`default_nettype wire

/* dv/host_model.sv */
// Host word buffer model: step a then step b for each ready character
`default_nettype none
module host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic char_ready,
  input  wire logic stall,
  output var  logic host_accept_a,
  output var  logic host_accept_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q;
  // Stall freezes the host, as a late buffer would
  always_ff @(posedge aclk) begin
    if (!aresetn || !char_ready) cnt_q <= 5'h00;
    else if (!stall && cnt_q != 5'h14) cnt_q <= cnt_q + 5'h01;
  end
  assign host_accept_a = cnt_q >= 5'h04 && cnt_q < 5'h0c;
  assign host_accept_b = cnt_q >= 5'h0c;
endmodule // host_model
`default_nettype wire

/* dv/tb_top.sv */
// Testbench for character gating and staging
`include "tape_char_map.svh"
`default_nettype none
module tb_top import tape_char_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, stall = 0, ha, hb;
  tape_pins_t  pins_q = '{tape_op_active: 1'b1, default: '0}, pins;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        wsg, rag, cr, bf, sf, fp;
  logic [1:0]  bresp, rresp;
  logic [6:0]  stg;
  int          errors = 0, n_compared = 0, cyc = 0;

  always #4 aclk = ~aclk;
  always_comb begin
    pins = pins_q;
    pins.host_accept_a = ha;
    pins.host_accept_b = hb;
  end
  tape_char_gating_and_staging DUT (.aclk(aclk), .aresetn(aresetn),
    .pins(pins), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .write_skew_gate(wsg), .read_accept_gate(rag), .staging_reg(stg),
    .char_ready(cr), .both_full(bf), .skew_fault(sf), .fault_pulse(fp));
  host_model u_host (.aclk(aclk), .aresetn(aresetn), .char_ready(cr),
    .stall(stall), .host_accept_a(ha), .host_accept_b(hb));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  // Bits fall while the detect clock is high; returns at its fall
  task automatic char_cyc(input logic [6:0] t);
    @(posedge aclk);
    pins_q.char_detect_clock <= 1'b1;
    pins_q.deskewed_track_pulses <= t;
    repeat (10) @(posedge aclk);
    pins_q.deskewed_track_pulses <= 7'h00;
    repeat (10) @(posedge aclk);
    pins_q.char_detect_clock <= 1'b0;
  endtask
  task automatic gate_w(input bit wr, input int exp);
    int w;
    w = 0;
    repeat (20) if ((wr ? wsg : rag) !== 1'b1) @(posedge aclk);
    while ((wr ? wsg : rag) === 1'b1) begin
      @(posedge aclk);
      w++;
    end
    check(w, exp);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    axi_rd(`CTRL_OFF, 32'h0, `RESP_OKAY);
    axi_rd(`STATUS_OFF, 32'h0, `RESP_OKAY);
    axi_rd(8'h0c, 32'h0, `RESP_SLVERR);
    axi_wr(8'h0c, 32'h1, `RESP_SLVERR);
    axi_wr(`STATUS_OFF, 32'h3f, `RESP_OKAY);
    axi_rd(`STATUS_OFF, 32'h0, `RESP_OKAY);
    axi_wr(`CTRL_OFF, 32'ha, `RESP_OKAY);
    axi_rd(`CTRL_OFF, 32'h2, `RESP_OKAY);
  endtask
  task automatic t_read();
    char_cyc(7'h55);
    repeat (8) @(posedge aclk);
    check(rag, 1'b1);
    check(cr, 1'b1);
    check(stg, 7'h55);
    repeat (40) @(posedge aclk);
    check(cr, 1'b0);
    repeat (700) @(posedge aclk);
  endtask
  task automatic t_full();
    stall <= 1'b1;
    char_cyc(7'h11);
    gate_w(1'b0, 500);
    check(stg, 7'h11);
    char_cyc(7'h22);
    repeat (8) @(posedge aclk);
    check(bf, 1'b1);
    check(stg, 7'h11);
    stall <= 1'b0;
    repeat (12) @(posedge aclk);
    check(bf, 1'b0);
    check(stg, 7'h22);
    repeat (700) @(posedge aclk);
    check(cr, 1'b0);
  endtask
  task automatic t_gap();
    pins_q.gap_crossing <= 1'b1;
    char_cyc(7'h7f);
    repeat (8) @(posedge aclk);
    check(stg, 7'h00);
    pins_q.gap_crossing <= 1'b0;
    axi_wr(`CTRL_OFF, 32'h6, `RESP_OKAY);
    repeat (4) @(posedge aclk);
    check(rag, 1'b0);
    char_cyc(7'h01);
    repeat (8) @(posedge aclk);
    check(rag, 1'b0);
    // Let the blocked gate run out, else it reappears after the start
    repeat (540) @(posedge aclk);
    axi_wr(`CTRL_OFF, 32'ha, `RESP_OKAY);
    axi_rd(`STATUS_OFF, 32'h0, `RESP_OKAY);
    // Check window lifts the gap inhibit; a stale 0x01 would show here
    pins_q.gap_crossing <= 1'b1;
    pins_q.check_char_window <= 1'b1;
    char_cyc(7'h08);
    repeat (8) @(posedge aclk);
    check(stg, 7'h08);
    pins_q.gap_crossing <= 1'b0;
    pins_q.check_char_window <= 1'b0;
    pins_q.gap_timer_one <= 1'b1;
    repeat (4) @(posedge aclk);
    check(rag, 1'b0);
    repeat (540) @(posedge aclk);
    pins_q.gap_timer_one <= 1'b0;
  endtask
  task automatic t_write();
    pins_q.xfer_out_mode <= 1'b1;
    char_cyc(7'h01);
    gate_w(1'b1, 125);
    check(sf, 1'b0);
    char_cyc(7'h00);
    repeat (10) @(posedge aclk);
    // A late bit on one track inside the skew gate
    pins_q.deskewed_track_pulses <= 7'h02;
    repeat (4) @(posedge aclk);
    pins_q.deskewed_track_pulses <= 7'h00;
    repeat (6) @(posedge aclk);
    check(sf, 1'b1);
    check(fp, 1'b1);
    repeat (200) @(posedge aclk);
    check(sf, 1'b0);
    check(fp, 1'b1);
    // Lockout masks the late bit, so no fault this time
    pins_q.first_pulse_lockout <= 1'b1;
    char_cyc(7'h00);
    repeat (10) @(posedge aclk);
    pins_q.deskewed_track_pulses <= 7'h02;
    repeat (4) @(posedge aclk);
    pins_q.deskewed_track_pulses <= 7'h00;
    repeat (6) @(posedge aclk);
    check(sf, 1'b0);
  endtask
  ////////////////////////////////////////
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_read();
    t_full();
    t_gap();
    t_write();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
